/* File: rxpr_consts.svh */
// offsets, field positions, reset values and codes of the per-port remote map registers
`ifndef RXPR_CONSTS_SVH
`define RXPR_CONSTS_SVH

`define RXPR_NUM_PORTS 4
`define RXPR_PORT_SEL_REG 8'h4C
`define RXPR_OFS_FWD_CTL1 8'h59
`define RXPR_OFS_FWD_CTL2 8'h5A
`define RXPR_OFS_SER_ADDR 8'h5B
`define RXPR_OFS_SER_ALIAS 8'h5C
`define RXPR_OFS_TGT_ADDR0 8'h5D
`define RXPR_OFS_TGT_ADDR1 8'h5E

`define RXPR_BIT_OVERRIDE 7
`define RXPR_BIT_FREEZE 0
`define RXPR_BIT_AUTO_ACK 0
`define RXPR_ADDR_MSB 7
`define RXPR_ADDR_LSB 1
`define RXPR_GPIO_MSB 1
`define RXPR_GPIO_LSB 0

`define RXPR_RST_BYTE 8'h00
`define RXPR_RST_ADDR 7'h00
`define RXPR_RST_GPIO 2'h0
`define RXPR_RST_MASK 4'h0
`define RXPR_ALIAS_OFF 7'h00

`define RXPR_GPIO_NONE 2'h0
`define RXPR_GPIO_ONE 2'h1
`define RXPR_GPIO_TWO 2'h2
`define RXPR_GPIO_FOUR 2'h3

`endif

/* File: rxpr_link_model.sv */
// forward-link side of the remote serializer: pushes identity and gpio count loads
`timescale 1ns/1ps
`default_nettype none
module rxpr_link_model (
    input wire logic mclk, // core clock
    input wire logic arst_n, // reset, active low
    input wire logic sendReq, // send one load
    input wire logic [1:0] sendPort, // port to load
    input wire logic [6:0] sendAddr, // serializer identity
    input wire logic [1:0] sendGpio, // gpio count
    output logic [3:0] fwdLoadStb, // load strobe per port
    output logic [6:0] fwdLoadAddr, // identity lines
    output logic [1:0] fwdLoadGpio // count lines
);
    // idle data flips every cycle so a load taken without its strobe shows up
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            fwdLoadStb <= 4'h0;
            fwdLoadAddr <= 7'h55;
            fwdLoadGpio <= 2'h2;
        end else begin
            fwdLoadStb <= sendReq ? 4'h1 << sendPort : 4'h0;
            fwdLoadAddr <= sendReq ? sendAddr : ~fwdLoadAddr;
            fwdLoadGpio <= sendReq ? sendGpio : ~fwdLoadGpio;
        end
    end
endmodule
`default_nettype wire

/* File: rxpr_pkg.sv */
// types shared by the per-port remote map register bank
`default_nettype none
package rxpr_pkg;
    typedef logic [6:0] rxpr_addr_t;
    typedef logic [1:0] rxpr_port_t;
    typedef logic [1:0] rxpr_gpio_t;
    typedef enum logic [1:0] {
        RXPR_HIT_NONE,
        RXPR_HIT_SER,
        RXPR_HIT_TGT0,
        RXPR_HIT_TGT1
    } rxpr_hit_e;
endpackage
`default_nettype wire

/* File: rxpr_remote_map.sv */
// per-receive-port remote serializer address map, forward load control and alias remapping
//
// Functional notes
// - register accesses reach the copy of the port chosen by the port-select register.
// - override bit 7 set blocks forward-channel gpio count loads and keeps the local count.
// - gpio count field 00 none, 01 one, 10 two, 11 four forward gpios.
// - gpio count loads from serializer; local write persists only with override set.
// - serializer address field is auto-filled with identity received over forward link.
// - freeze bit 0 blocks the address auto-load and holds the written address.
// - serializer alias decodes local transactions and remaps them to the serializer address.
// - alias value zero never decodes a transaction as remote access.
// - auto-ack bit set acknowledges every write to the remote serializer.
// - target address registers remap transactions matching their target alias.
`timescale 1ns/1ps
`default_nettype none
`include "rxpr_consts.svh"

module rxpr_remote_map (
    input wire logic mclk,                                          // core clock, 100 MHz
    input wire logic arst_n,                                        // async reset, active low
    input wire logic [1:0] portSel,                                 // port chosen by port-select
    input wire logic regWrEn,                                       // register write strobe
    input wire logic regRdEn,                                       // register read strobe
    input wire logic [7:0] regAddr,                                 // register offset
    input wire logic [7:0] regWrData,                               // register write data
    output logic [7:0] regRdData,                                   // read data, one cycle later
    output logic regRdValid,                                        // read data valid pulse
    input wire logic [3:0] fwdLoadStb,                              // forward-link load, per port
    input wire logic [1:0] fwdLoadGpio,                             // gpio count from serializer
    input wire logic [6:0] fwdLoadAddr,                             // identity from serializer
    input wire logic [3:0][6:0] tgtAlias0,                          // target alias 0, per port
    input wire logic [3:0][6:0] tgtAlias1,                          // target alias 1, per port
    input wire logic txnValid,                                      // local transaction start
    input wire logic [6:0] txnAddr,                                 // local seven-bit address
    input wire logic txnWrite,                                      // local transaction is write
    output logic fwdValid,                                          // remote match pulse
    output logic [1:0] fwdPort,                                     // port the match belongs to
    output logic [6:0] fwdAddr,                                     // remapped physical address
    output logic fwdAutoAck,                                        // ack locally, no wait
    output logic [3:0][1:0] fwdGpioCount,                           // gpio count per port
    output logic [3:0][3:0] fwdGpioEnable                           // active gpio mask per port
);

    // ------------------------------------------------------------
    // per-port register copies
    // ------------------------------------------------------------
    logic [3:0] override_r;
    logic [3:0] freeze_r;
    logic [3:0] autoAck_r;
    rxpr_pkg::rxpr_gpio_t gpioCount_r [4];
    rxpr_pkg::rxpr_addr_t serAddr_r [4];
    rxpr_pkg::rxpr_addr_t serAlias_r [4];
    rxpr_pkg::rxpr_addr_t tgtAddr0_r [4];
    rxpr_pkg::rxpr_addr_t tgtAddr1_r [4];

    genvar gp;
    generate
        for (gp = 0; gp < `RXPR_NUM_PORTS; gp = gp + 1) begin : g_port
            logic selWr;
            logic overrideNxt;
            logic freezeNxt;
            logic autoAckNxt;
            rxpr_pkg::rxpr_gpio_t gpioNxt;
            rxpr_pkg::rxpr_addr_t serAddrNxt;
            rxpr_pkg::rxpr_addr_t aliasNxt;
            rxpr_pkg::rxpr_addr_t tgt0Nxt;
            rxpr_pkg::rxpr_addr_t tgt1Nxt;
            logic loadGpio;
            logic loadAddr;
            logic [3:0] gpioEnableNxt;
            logic [3:0] gpioEnable_r;

            assign selWr = regWrEn && (portSel == 2'(gp));
            // blocking bits are taken before any same-cycle local write lands
            assign loadGpio = fwdLoadStb[gp] && !override_r[gp];
            assign loadAddr = fwdLoadStb[gp] && !freeze_r[gp];

            always_comb begin
                overrideNxt = override_r[gp];
                freezeNxt = freeze_r[gp];
                autoAckNxt = autoAck_r[gp];
                gpioNxt = gpioCount_r[gp];
                serAddrNxt = serAddr_r[gp];
                aliasNxt = serAlias_r[gp];
                tgt0Nxt = tgtAddr0_r[gp];
                tgt1Nxt = tgtAddr1_r[gp];
                // reserved bits are simply not stored
                if (selWr) begin
                    unique case (regAddr)
                        `RXPR_OFS_FWD_CTL1: begin
                            overrideNxt = regWrData[`RXPR_BIT_OVERRIDE];
                            gpioNxt = regWrData[`RXPR_GPIO_MSB:`RXPR_GPIO_LSB];
                        end
                        `RXPR_OFS_SER_ADDR: begin
                            serAddrNxt = regWrData[`RXPR_ADDR_MSB:`RXPR_ADDR_LSB];
                            freezeNxt = regWrData[`RXPR_BIT_FREEZE];
                        end
                        `RXPR_OFS_SER_ALIAS: begin
                            aliasNxt = regWrData[`RXPR_ADDR_MSB:`RXPR_ADDR_LSB];
                            autoAckNxt = regWrData[`RXPR_BIT_AUTO_ACK];
                        end
                        `RXPR_OFS_TGT_ADDR0: tgt0Nxt = regWrData[`RXPR_ADDR_MSB:`RXPR_ADDR_LSB];
                        `RXPR_OFS_TGT_ADDR1: tgt1Nxt = regWrData[`RXPR_ADDR_MSB:`RXPR_ADDR_LSB];
                        default: ;
                    endcase
                end
                // link load applied after the local write: without override the
                // serializer owns the field, so a colliding local write is lost
                if (loadGpio) begin
                    gpioNxt = fwdLoadGpio;
                end
                if (loadAddr) begin
                    serAddrNxt = fwdLoadAddr;
                end
            end

            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    override_r[gp] <= 1'b0;
                    freeze_r[gp] <= 1'b0;
                    autoAck_r[gp] <= 1'b0;
                    gpioCount_r[gp] <= `RXPR_RST_GPIO;
                    serAddr_r[gp] <= `RXPR_RST_ADDR;
                    serAlias_r[gp] <= `RXPR_RST_ADDR;
                    tgtAddr0_r[gp] <= `RXPR_RST_ADDR;
                    tgtAddr1_r[gp] <= `RXPR_RST_ADDR;
                end else begin
                    override_r[gp] <= overrideNxt;
                    freeze_r[gp] <= freezeNxt;
                    autoAck_r[gp] <= autoAckNxt;
                    gpioCount_r[gp] <= gpioNxt;
                    serAddr_r[gp] <= serAddrNxt;
                    serAlias_r[gp] <= aliasNxt;
                    tgtAddr0_r[gp] <= tgt0Nxt;
                    tgtAddr1_r[gp] <= tgt1Nxt;
                end
            end

            // mask decoded from the next count, so mask and count move on one edge
            always_comb begin
                gpioEnableNxt = `RXPR_RST_MASK;
                unique case (gpioNxt)
                    `RXPR_GPIO_NONE: gpioEnableNxt = 4'h0;
                    `RXPR_GPIO_ONE: gpioEnableNxt = 4'h1;
                    `RXPR_GPIO_TWO: gpioEnableNxt = 4'h3;
                    `RXPR_GPIO_FOUR: gpioEnableNxt = 4'hF;
                endcase
            end

            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    gpioEnable_r <= `RXPR_RST_MASK;
                end else begin
                    gpioEnable_r <= gpioEnableNxt;
                end
            end

            assign fwdGpioCount[gp] = gpioCount_r[gp];
            assign fwdGpioEnable[gp] = gpioEnable_r;
        end
    endgenerate

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    logic [7:0] rdData_r;
    logic [7:0] rdDataNxt;
    logic rdValid_r;
    logic selOverride;
    logic selFreeze;
    logic selAutoAck;
    rxpr_pkg::rxpr_gpio_t selGpio;
    rxpr_pkg::rxpr_addr_t selSerAddr;
    rxpr_pkg::rxpr_addr_t selAlias;
    rxpr_pkg::rxpr_addr_t selTgt0;
    rxpr_pkg::rxpr_addr_t selTgt1;

    // one copy is picked first, so the offset mux below stays one byte wide
    assign selOverride = override_r[portSel];
    assign selFreeze = freeze_r[portSel];
    assign selAutoAck = autoAck_r[portSel];
    assign selGpio = gpioCount_r[portSel];
    assign selSerAddr = serAddr_r[portSel];
    assign selAlias = serAlias_r[portSel];
    assign selTgt0 = tgtAddr0_r[portSel];
    assign selTgt1 = tgtAddr1_r[portSel];

    always_comb begin
        rdDataNxt = `RXPR_RST_BYTE;
        if (regRdEn) begin
            unique case (regAddr)
                `RXPR_OFS_FWD_CTL1:
                    rdDataNxt = {selOverride, 5'h00, selGpio};
                `RXPR_OFS_SER_ADDR:
                    rdDataNxt = {selSerAddr, selFreeze};
                `RXPR_OFS_SER_ALIAS:
                    rdDataNxt = {selAlias, selAutoAck};
                `RXPR_OFS_TGT_ADDR0:
                    rdDataNxt = {selTgt0, 1'b0};
                `RXPR_OFS_TGT_ADDR1:
                    rdDataNxt = {selTgt1, 1'b0};
                default: rdDataNxt = `RXPR_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdData_r <= `RXPR_RST_BYTE;
            rdValid_r <= 1'b0;
        end else begin
            rdData_r <= rdDataNxt;
            rdValid_r <= regRdEn;
        end
    end

    assign regRdData = rdData_r;
    assign regRdValid = rdValid_r;

    // ------------------------------------------------------------
    // alias decode and remap
    // ------------------------------------------------------------
    // every port is compared at once; the lowest port wins and within a port
    // the serializer alias beats the target aliases, should software alias twice
    rxpr_pkg::rxpr_hit_e hitKind [4];

    generate
        for (gp = 0; gp < `RXPR_NUM_PORTS; gp = gp + 1) begin : g_dec
            logic serHit;
            logic tgt0Hit;
            logic tgt1Hit;

            // a cleared alias switches its decoder off instead of matching address zero
            assign serHit = serAlias_r[gp] != `RXPR_ALIAS_OFF && txnAddr == serAlias_r[gp];
            assign tgt0Hit = tgtAlias0[gp] != `RXPR_ALIAS_OFF && txnAddr == tgtAlias0[gp];
            assign tgt1Hit = tgtAlias1[gp] != `RXPR_ALIAS_OFF && txnAddr == tgtAlias1[gp];

            always_comb begin
                hitKind[gp] = rxpr_pkg::RXPR_HIT_NONE;
                if (serHit) begin
                    hitKind[gp] = rxpr_pkg::RXPR_HIT_SER;
                end else if (tgt0Hit) begin
                    hitKind[gp] = rxpr_pkg::RXPR_HIT_TGT0;
                end else if (tgt1Hit) begin
                    hitKind[gp] = rxpr_pkg::RXPR_HIT_TGT1;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // remap output register
    // ------------------------------------------------------------
    logic fwdValid_r;
    logic fwdValidNxt;
    logic [1:0] fwdPort_r;
    logic [1:0] fwdPortNxt;
    rxpr_pkg::rxpr_addr_t fwdAddr_r;
    rxpr_pkg::rxpr_addr_t fwdAddrNxt;
    logic fwdAutoAck_r;
    logic fwdAutoAckNxt;

    always_comb begin
        fwdValidNxt = 1'b0;
        fwdPortNxt = fwdPort_r;
        fwdAddrNxt = fwdAddr_r;
        fwdAutoAckNxt = 1'b0;
        for (int p = `RXPR_NUM_PORTS - 1; p >= 0; p--) begin
            if (txnValid && hitKind[p] != rxpr_pkg::RXPR_HIT_NONE) begin
                fwdValidNxt = 1'b1;
                fwdPortNxt = 2'(p);
                unique case (hitKind[p])
                    rxpr_pkg::RXPR_HIT_SER: fwdAddrNxt = serAddr_r[p];
                    rxpr_pkg::RXPR_HIT_TGT0: fwdAddrNxt = tgtAddr0_r[p];
                    rxpr_pkg::RXPR_HIT_TGT1: fwdAddrNxt = tgtAddr1_r[p];
                    rxpr_pkg::RXPR_HIT_NONE: fwdAddrNxt = fwdAddr_r;
                endcase
                // ack without waiting on lock or the far ack, for writes only
                fwdAutoAckNxt = txnWrite && autoAck_r[p] &&
                                hitKind[p] == rxpr_pkg::RXPR_HIT_SER;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            fwdValid_r <= 1'b0;
            fwdPort_r <= 2'h0;
            fwdAddr_r <= `RXPR_RST_ADDR;
            fwdAutoAck_r <= 1'b0;
        end else begin
            fwdValid_r <= fwdValidNxt;
            fwdPort_r <= fwdPortNxt;
            fwdAddr_r <= fwdAddrNxt;
            fwdAutoAck_r <= fwdAutoAckNxt;
        end
    end

    assign fwdValid = fwdValid_r;
    assign fwdPort = fwdPort_r;
    assign fwdAddr = fwdAddr_r;
    assign fwdAutoAck = fwdAutoAck_r;

endmodule
`default_nettype wire

/* File: rxpr_remote_map_assertions.sv */
// concurrent checks on the remote map ports
`timescale 1ns/1ps
`default_nettype none
module rxpr_remote_map_assertions (
    input wire logic mclk, // clock
    input wire logic arst_n, // reset
    input wire logic regWrEn, // write strobe
    input wire logic regRdEn, // read strobe
    input wire logic [7:0] regAddr, // offset
    input wire logic [7:0] regRdData, // read data
    input wire logic regRdValid, // read valid
    input wire logic [3:0] fwdLoadStb, // link load
    input wire logic txnValid, // local txn
    input wire logic [6:0] txnAddr, // txn address
    input wire logic txnWrite, // txn is write
    input wire logic fwdValid, // remote match
    input wire logic fwdAutoAck, // local ack
    input wire logic [3:0][1:0] fwdGpioCount, // gpio count
    input wire logic [3:0][3:0] fwdGpioEnable // gpio mask
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic unmapped;
    assign unmapped = regAddr < 8'h59 || regAddr > 8'h5E || regAddr == 8'h5A;
    sequence sRdAnswer;
        ##1 regRdValid;
    endsequence
    sequence sRdZero;
        ##1 (regRdValid && regRdData == 8'h00);
    endsequence
    AST_RD_ANSWER: assert property (regRdEn |-> sRdAnswer)
        else $error("read gave no answer");
    AST_RD_ONCE: assert property (!regRdEn |=> !regRdValid && regRdData == 8'h00)
        else $error("read data outside its cycle");
    AST_UNMAPPED: assert property (regRdEn && unmapped |-> sRdZero)
        else $error("unmapped read not zero");
    for (genvar p = 0; p < 4; p++) begin : g_mask
        AST_GPIO_MASK: assert property (fwdGpioEnable[p] == {{2{&fwdGpioCount[p]}},
            fwdGpioCount[p][1], |fwdGpioCount[p]}) else $error("gpio mask wrong");
    end
    // the count may only move on a local write or a link load, never on its own
    AST_GPIO_CAUSE: assert property ($changed(fwdGpioCount) |->
        $past(regWrEn) || $past(fwdLoadStb) != 4'h0) else $error("gpio count moved");
    AST_AUTOACK: assert property (fwdAutoAck |-> fwdValid && $past(txnWrite))
        else $error("auto ack without write");
    AST_NO_TXN: assert property (!txnValid |=> !fwdValid)
        else $error("forward without transaction");
    AST_ZERO_ALIAS: assert property (txnValid && txnAddr == 7'h00 |=> !fwdValid)
        else $error("zero address forwarded");
endmodule
bind rxpr_remote_map rxpr_remote_map_assertions u_rxpr_remote_map_assertions (.mclk, .arst_n,
    .regWrEn, .regRdEn, .regAddr, .regRdData, .regRdValid, .fwdLoadStb, .txnValid, .txnAddr,
    .txnWrite, .fwdValid, .fwdAutoAck, .fwdGpioCount, .fwdGpioEnable);
`default_nettype wire

/* File: test_rx_port_remote_i2c_map_regs.sv */
// self-checking bench for the per-port remote map registers
`timescale 1ns/1ps
`default_nettype none
module test_rx_port_remote_i2c_map_regs;
    logic mclk = 1'b0, arst_n = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0, regRdValid;
    logic txnValid = 1'b0, txnWrite = 1'b0, fwdValid, fwdAutoAck, sendReq = 1'b0;
    logic [1:0] portSel = 2'h0, fwdPort, fwdLoadGpio, sendPort = 2'h0, sendGpio = 2'h0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
    logic [6:0] txnAddr = 7'h00, fwdAddr, fwdLoadAddr, sendAddr = 7'h00;
    logic [3:0] fwdLoadStb;
    logic [3:0][6:0] tgtAlias0 = 28'h0002800, tgtAlias1 = 28'h0144000;
    logic [3:0][1:0] fwdGpioCount;
    logic [3:0][3:0] fwdGpioEnable;
    logic [3:0] gpioMask [4] = '{4'h0, 4'h1, 4'h3, 4'hF};
    int n_errors = 0, total_checks = 0;
    typedef struct packed {logic w; logic [1:0] p; logic [7:0] a, d, e;} rxpr_row_s;
    rxpr_row_s rows [8] = '{
        '{1'b1, 2'h0, 8'h59, 8'hFF, 8'h83}, '{1'b1, 2'h1, 8'h5A, 8'hFF, 8'h00},
        '{1'b1, 2'h2, 8'h5B, 8'hA5, 8'hA5}, '{1'b1, 2'h3, 8'h5C, 8'h35, 8'h35},
        '{1'b1, 2'h1, 8'h5D, 8'hFF, 8'hFE}, '{1'b1, 2'h2, 8'h5E, 8'h43, 8'h42},
        '{1'b1, 2'h0, 8'h70, 8'hFF, 8'h00}, '{1'b0, 2'h1, 8'h5B, 8'h00, 8'h00}};
    rxpr_remote_map u_rxpr_remote_map (.mclk, .arst_n, .portSel, .regWrEn, .regRdEn,
        .regAddr, .regWrData, .regRdData, .regRdValid, .fwdLoadStb, .fwdLoadGpio,
        .fwdLoadAddr, .tgtAlias0, .tgtAlias1, .txnValid, .txnAddr, .txnWrite, .fwdValid,
        .fwdPort, .fwdAddr, .fwdAutoAck, .fwdGpioCount, .fwdGpioEnable);
    rxpr_link_model u_rxpr_link_model (.mclk, .arst_n, .sendReq, .sendPort, .sendAddr,
        .sendGpio, .fwdLoadStb, .fwdLoadAddr, .fwdLoadGpio);
    task automatic chk(input logic ok, input string m);
        total_checks++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    // optional write, then a back-to-back read of the same place
    task automatic acc(input rxpr_row_s r);
        @(posedge mclk) #1;
        portSel = r.p;
        regAddr = r.a;
        regWrData = r.d;
        regWrEn = r.w;
        @(posedge mclk) #1;
        regWrEn = 1'b0;
        regRdEn = 1'b1;
        @(posedge mclk) #1;
        regRdEn = 1'b0;
        chk(regRdValid === 1'b1 && regRdData === r.e, "read data");
    endtask
    task automatic load(input logic [1:0] p, g, input logic [6:0] a);
        @(posedge mclk) #1;
        sendPort = p;
        sendGpio = g;
        sendAddr = a;
        sendReq = 1'b1;
        @(posedge mclk) #1;
        sendReq = 1'b0;
        @(posedge mclk) #1;
    endtask
    task automatic txn(input logic [6:0] a, input logic w, v, input logic [1:0] p,
        input logic [6:0] e, input logic k);
        @(posedge mclk) #1;
        txnAddr = a;
        txnWrite = w;
        txnValid = 1'b1;
        @(posedge mclk) #1;
        txnValid = 1'b0;
        chk(fwdValid === v && (!v || (fwdPort === p && fwdAddr === e && fwdAutoAck === k)),
            "forward");
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (3000) @(posedge mclk);
        n_errors++;
        stop_test();
    end
    initial begin
        repeat (16) @(posedge mclk);
        #1 arst_n = 1'b1;
        foreach (rows[i]) acc(rows[i]);
        load(2'h0, 2'h1, 7'h11);
        chk(fwdGpioCount[0] === 2'h3 && fwdGpioEnable[0] === 4'hF, "override");
        acc('{1'b0, 2'h0, 8'h5B, 8'h00, 8'h22});
        load(2'h2, 2'h2, 7'h12);
        chk(fwdGpioCount[2] === 2'h2, "gpio load");
        acc('{1'b0, 2'h2, 8'h5B, 8'h00, 8'hA5});
        for (int c = 0; c < 4; c++) begin
            load(2'h3, c[1:0], 7'h2C);
            chk(fwdGpioCount[3] === c[1:0] && fwdGpioEnable[3] === gpioMask[c], "gpio");
        end
        txn(7'h1A, 1'b1, 1'b1, 2'h3, 7'h2C, 1'b1);
        txn(7'h1A, 1'b0, 1'b1, 2'h3, 7'h2C, 1'b0);
        txn(7'h50, 1'b1, 1'b1, 2'h1, 7'h7F, 1'b0);
        txn(7'h51, 1'b0, 1'b1, 2'h2, 7'h21, 1'b0);
        txn(7'h00, 1'b1, 1'b0, 2'h0, 7'h00, 1'b0);
        txn(7'h33, 1'b1, 1'b0, 2'h0, 7'h00, 1'b0);
        arst_n = 1'b0;
        repeat (2) @(posedge mclk);
        #1 arst_n = 1'b1;
        chk(fwdGpioEnable === 16'h0000 && fwdValid === 1'b0, "reset outputs");
        acc('{1'b0, 2'h2, 8'h5B, 8'h00, 8'h00});
        stop_test();
    end
endmodule
`default_nettype wire
